// File: rtl/bsfx_exec.sv
// bit, shift, flag, sleep, watchdog and indirect transfer execution unit
`timescale 1ns/1ps
`include "bsfx_consts.svh"

module bsfx_exec (
   input  wire  logic                  CLOCK,
   input  wire  logic                  RST,
   input  wire  logic                  REQ_VALID,
   input  wire  bsfx_pkg::bsfx_req_t   REQ,
   output logic                        REQ_READY,
   output logic                        RES_VALID,
   output bsfx_pkg::bsfx_res_t         RES,
   output bsfx_pkg::bsfx_flags_t       STATUS_FLAGS,
   output logic                        MEM_RD,
   output logic                        MEM_WR,
   output logic                        PMEM_RD,
   output logic [7:0]                  MEM_WDATA,
   input  wire  logic [7:0]            MEM_RDATA,
   output logic                        SLEEP_ENTER,
   output logic                        WDOG_RESTART
);
   import bsfx_pkg::*;

   bsfx_state_t state_q,   state_d;
   logic [1:0]  cnt_q,     cnt_d;
   bsfx_op_t    op_q,      op_d;
   bsfx_res_t   res_q,     res_d;
   bsfx_flags_t flags_q,   flags_d;
   logic        valid_q,   valid_d;
   logic        mem_rd_q,  mem_rd_d;
   logic        mem_wr_q,  mem_wr_d;
   logic        pmem_rd_q, pmem_rd_d;
   logic [7:0]  wdata_q,   wdata_d;
   logic        sleep_q,   sleep_d;
   logic        wdog_q,    wdog_d;
   logic        accept;

   // zero, carry, negative, overflow and signed test after any shift or rotate
   function automatic bsfx_flags_t shift_flags(input bsfx_flags_t cur, input logic [7:0] r, input logic co);
      bsfx_flags_t f;
      f   = cur;
      f.c = co;
      f.n = r[7];
      f.z = (r == 8'h00);
      f.v = r[7] ^ co;
      f.s = r[7] ^ (r[7] ^ co);
      return f;
   endfunction

   assign REQ_READY = (state_q == STATE_IDLE);
   assign accept    = REQ_VALID && REQ_READY;

   always_comb begin
      logic [1:0] cyc;
      logic [7:0] a;
      logic [7:0] mask;
      cyc       = `BSFX_CYC_SINGLE;
      a         = REQ.opnd;
      mask      = `BSFX_BIT_ONE << REQ.bitsel;
      state_d   = state_q;
      cnt_d     = cnt_q;
      op_d      = op_q;
      res_d     = res_q;
      flags_d   = flags_q;
      valid_d   = 1'b0;
      mem_rd_d  = 1'b0;
      mem_wr_d  = 1'b0;
      pmem_rd_d = 1'b0;
      wdata_d   = wdata_q;
      sleep_d   = 1'b0;
      wdog_d    = 1'b0;
      if (state_q == STATE_BUSY) begin
         cnt_d = cnt_q - 2'h1;
         // read strobes stay up until the cycle that samples the byte
         mem_rd_d  = (op_q == OP_INDIRECT_LOAD) && (cnt_q > 2'h1);
         pmem_rd_d = (op_q == OP_PROGRAM_MEMORY_LOAD) && (cnt_q > 2'h1);
         if (cnt_q == 2'h1) begin
            state_d = STATE_IDLE;
            valid_d = 1'b1;
            if (op_q == OP_INDIRECT_LOAD || op_q == OP_PROGRAM_MEMORY_LOAD) begin
               res_d.data = MEM_RDATA;
            end
            sleep_d = (op_q == OP_SLEEP);
         end
      end else if (accept) begin
         op_d       = REQ.op;
         res_d.dest = DEST_NONE;
         case (REQ.op)
            OP_SHIFT_LEFT_LOGICAL: begin
               res_d  = '{DEST_REG, {a[6:0], 1'b0}};
               flags_d = shift_flags(flags_q, {a[6:0], 1'b0}, a[7]);
            end
            OP_SHIFT_RIGHT_LOGICAL: begin
               res_d  = '{DEST_REG, {1'b0, a[7:1]}};
               flags_d = shift_flags(flags_q, {1'b0, a[7:1]}, a[0]);
            end
            OP_ROTATE_LEFT_CARRY: begin
               res_d  = '{DEST_REG, {a[6:0], flags_q.c}};
               flags_d = shift_flags(flags_q, {a[6:0], flags_q.c}, a[7]);
            end
            OP_ROTATE_RIGHT_CARRY: begin
               res_d  = '{DEST_REG, {flags_q.c, a[7:1]}};
               flags_d = shift_flags(flags_q, {flags_q.c, a[7:1]}, a[0]);
            end
            OP_SHIFT_RIGHT_ARITH: begin
               res_d  = '{DEST_REG, {a[7], a[7:1]}};
               flags_d = shift_flags(flags_q, {a[7], a[7:1]}, a[0]);
            end
            OP_IO_BIT_SET: begin
               // opnd carries the current io register contents for read-modify-write
               res_d = '{DEST_IO, a | mask};
               cyc   = `BSFX_CYC_IO_BIT;
            end
            OP_IO_BIT_CLEAR: begin
               res_d = '{DEST_IO, a & ~mask};
               cyc   = `BSFX_CYC_IO_BIT;
            end
            OP_BIT_TO_TRANSFER_FLAG: flags_d.t = a[REQ.bitsel];
            OP_TRANSFER_FLAG_TO_BIT: res_d = '{DEST_REG, flags_q.t ? (a | mask) : (a & ~mask)};
            OP_OVERFLOW_FLAG_SET:    flags_d.v = 1'b1;
            OP_OVERFLOW_FLAG_CLEAR:  flags_d.v = 1'b0;
            OP_HALF_CARRY_SET:       flags_d.h = 1'b1;
            OP_HALF_CARRY_CLEAR:     flags_d.h = 1'b0;
            OP_SIGN_FLAG_SET:        flags_d.s = 1'b1;
            OP_SIGN_FLAG_CLEAR:      flags_d.s = 1'b0;
            OP_SLEEP:                cyc = `BSFX_CYC_SLEEP;
            OP_WATCHDOG_RESTART:     wdog_d = 1'b1;
            OP_INDIRECT_LOAD: begin
               res_d.dest = DEST_REG;
               mem_rd_d   = 1'b1;
               cyc        = `BSFX_CYC_MEM;
            end
            OP_INDIRECT_STORE: begin
               res_d    = '{DEST_MEM, a};
               mem_wr_d = 1'b1;
               wdata_d  = a;
               cyc      = `BSFX_CYC_MEM;
            end
            OP_PROGRAM_MEMORY_LOAD: begin
               res_d.dest = DEST_REG;
               pmem_rd_d  = 1'b1;
               cyc        = `BSFX_CYC_PMEM;
            end
            OP_NIBBLE_SWAP:          res_d = '{DEST_REG, {a[3:0], a[7:4]}};
            default:                 res_d.dest = DEST_NONE;
         endcase
         if (cyc == `BSFX_CYC_SINGLE) begin
            valid_d = 1'b1;
         end else begin
            // RES already shows the result, except load data that comes from MEM_RDATA at the end, but RES_VALID stays low until the last cycle of the instruction
            state_d = STATE_BUSY;
            cnt_d   = cyc - 2'h1;
         end
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         state_q   <= STATE_IDLE;
         cnt_q     <= 2'h0;
         op_q      <= OP_NOP;
         res_q     <= '{DEST_NONE, `BSFX_DATA_RST};
         flags_q   <= `BSFX_FLAGS_RST;
         valid_q   <= 1'b0;
         mem_rd_q  <= 1'b0;
         mem_wr_q  <= 1'b0;
         pmem_rd_q <= 1'b0;
         wdata_q   <= `BSFX_DATA_RST;
         sleep_q   <= 1'b0;
         wdog_q    <= 1'b0;
      end else begin
         state_q   <= state_d;
         cnt_q     <= cnt_d;
         op_q      <= op_d;
         res_q     <= res_d;
         flags_q   <= flags_d;
         valid_q   <= valid_d;
         mem_rd_q  <= mem_rd_d;
         mem_wr_q  <= mem_wr_d;
         pmem_rd_q <= pmem_rd_d;
         wdata_q   <= wdata_d;
         sleep_q   <= sleep_d;
         wdog_q    <= wdog_d;
      end
   end

   assign RES_VALID    = valid_q;
   assign RES          = res_q;
   assign STATUS_FLAGS = flags_q;
   assign MEM_RD       = mem_rd_q;
   assign MEM_WR       = mem_wr_q;
   assign PMEM_RD      = pmem_rd_q;
   assign MEM_WDATA    = wdata_q;
   assign SLEEP_ENTER  = sleep_q;
   assign WDOG_RESTART = wdog_q;

   // checks
   logic sel_bit;
   assign sel_bit = REQ.opnd[REQ.bitsel];

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);

   sequence s_acc(bsfx_op_t o);
      REQ_VALID && REQ_READY && REQ.op == o;
   endsequence
   sequence s_two_cycle_done;
      !RES_VALID && !REQ_READY ##1 RES_VALID && REQ_READY;
   endsequence

   AST_SHIFT_LEFT: assert property (s_acc(OP_SHIFT_LEFT_LOGICAL) |=> RES_VALID && RES.data[0] == 1'b0
      && RES.data[7:1] == $past(REQ.opnd[6:0]) && STATUS_FLAGS.c == $past(REQ.opnd[7]))
      else $error("shift left wrong");
   AST_SHIFT_RIGHT: assert property (s_acc(OP_SHIFT_RIGHT_LOGICAL) |=> RES_VALID && !STATUS_FLAGS.n
      && RES.data == {1'b0, $past(REQ.opnd[7:1])} && STATUS_FLAGS.c == $past(REQ.opnd[0]))
      else $error("shift right wrong");
   AST_ROT_LEFT: assert property (s_acc(OP_ROTATE_LEFT_CARRY) |=> RES.data[0] == $past(STATUS_FLAGS.c)
      && STATUS_FLAGS.c == $past(REQ.opnd[7]) && STATUS_FLAGS.v == (STATUS_FLAGS.n ^ STATUS_FLAGS.c))
      else $error("rotate left wrong");
   AST_ROT_RIGHT: assert property (s_acc(OP_ROTATE_RIGHT_CARRY) |=> RES.data[7] == $past(STATUS_FLAGS.c)
      && STATUS_FLAGS.c == $past(REQ.opnd[0]) && STATUS_FLAGS.z == (RES.data == 8'h00))
      else $error("rotate right wrong");
   AST_ARITH_SHIFT: assert property (s_acc(OP_SHIFT_RIGHT_ARITH) |=> RES.data[7] == $past(REQ.opnd[7])
      && RES.data[6:0] == $past(REQ.opnd[7:1])) else $error("arith shift wrong");
   AST_IO_SET: assert property (s_acc(OP_IO_BIT_SET) |=> s_two_cycle_done
      ##0 RES.dest == DEST_IO && STATUS_FLAGS == $past(STATUS_FLAGS, 2)
      && RES.data == ($past(REQ.opnd, 2) | (`BSFX_BIT_ONE << $past(REQ.bitsel, 2))))
      else $error("io bit set wrong");
   AST_IO_CLEAR: assert property (s_acc(OP_IO_BIT_CLEAR) |=> s_two_cycle_done
      ##0 RES.dest == DEST_IO && STATUS_FLAGS == $past(STATUS_FLAGS, 2)
      && RES.data == ($past(REQ.opnd, 2) & ~(`BSFX_BIT_ONE << $past(REQ.bitsel, 2))))
      else $error("io bit clear wrong");
   AST_T_STORE: assert property (s_acc(OP_BIT_TO_TRANSFER_FLAG) |=> STATUS_FLAGS.t == $past(sel_bit)
      && {STATUS_FLAGS.i, STATUS_FLAGS[5:0]} == $past({STATUS_FLAGS.i, STATUS_FLAGS[5:0]}))
      else $error("bit store wrong");
   AST_T_LOAD: assert property (s_acc(OP_TRANSFER_FLAG_TO_BIT) |=> RES_VALID
      && STATUS_FLAGS == $past(STATUS_FLAGS)) else $error("bit load altered flags");
   AST_OVF_SET: assert property (s_acc(OP_OVERFLOW_FLAG_SET) |=> STATUS_FLAGS.v && REQ_READY)
      else $error("overflow set wrong");
   AST_OVF_CLEAR: assert property (s_acc(OP_OVERFLOW_FLAG_CLEAR) |=> !STATUS_FLAGS.v)
      else $error("overflow clear wrong");
   AST_HC_SET: assert property (s_acc(OP_HALF_CARRY_SET) |=> STATUS_FLAGS.h)
      else $error("half carry set wrong");
   AST_HC_CLEAR: assert property (s_acc(OP_HALF_CARRY_CLEAR) |=> !STATUS_FLAGS.h)
      else $error("half carry clear wrong");
   AST_SIGN_SET: assert property (s_acc(OP_SIGN_FLAG_SET) |=> STATUS_FLAGS.s)
      else $error("sign flag set wrong");
   AST_SIGN_CLEAR: assert property (s_acc(OP_SIGN_FLAG_CLEAR) |=> !STATUS_FLAGS.s)
      else $error("sign flag clear wrong");
   AST_SLEEP: assert property (s_acc(OP_SLEEP) |=> !SLEEP_ENTER [*2] ##1 SLEEP_ENTER && RES_VALID)
      else $error("sleep timing wrong");
   AST_WDOG: assert property (s_acc(OP_WATCHDOG_RESTART) |=> WDOG_RESTART
      && STATUS_FLAGS == $past(STATUS_FLAGS)) else $error("watchdog restart wrong");
   AST_IND_LOAD: assert property (s_acc(OP_INDIRECT_LOAD) |=> MEM_RD && !RES_VALID ##1 RES_VALID && !MEM_RD
      && RES.data == $past(MEM_RDATA)) else $error("indirect load timing wrong");
   AST_IND_STORE: assert property (s_acc(OP_INDIRECT_STORE) |=> MEM_WR && !RES_VALID
      && MEM_WDATA == $past(REQ.opnd) ##1 RES_VALID && !MEM_WR) else $error("indirect store wrong");
   AST_PMEM_LOAD: assert property (s_acc(OP_PROGRAM_MEMORY_LOAD) |=> PMEM_RD [*2] ##1 RES_VALID && !PMEM_RD
      && RES.data == $past(MEM_RDATA)) else $error("program memory load timing wrong");
   AST_SWAP: assert property (s_acc(OP_NIBBLE_SWAP) |=> RES.data == {$past(REQ.opnd[3:0]), $past(REQ.opnd[7:4])})
      else $error("nibble swap wrong");

endmodule

// File: rtl/bsfx_consts.svh
// constants for the bit, shift and flag execution unit
`ifndef BSFX_CONSTS_SVH
`define BSFX_CONSTS_SVH

`define BSFX_FLAGS_RST  8'h00
`define BSFX_DATA_RST   8'h00
`define BSFX_CYC_SINGLE 2'h1
`define BSFX_CYC_IO_BIT 2'h2
`define BSFX_CYC_MEM    2'h2
`define BSFX_CYC_PMEM   2'h3
`define BSFX_CYC_SLEEP  2'h3
`define BSFX_BIT_ONE    8'h01

`endif

// File: rtl/bsfx_pkg.sv
// types for the bit, shift and flag execution unit
package bsfx_pkg;

   typedef enum logic [4:0] {
      OP_NOP,
      OP_SHIFT_LEFT_LOGICAL,
      OP_SHIFT_RIGHT_LOGICAL,
      OP_ROTATE_LEFT_CARRY,
      OP_ROTATE_RIGHT_CARRY,
      OP_SHIFT_RIGHT_ARITH,
      OP_IO_BIT_SET,
      OP_IO_BIT_CLEAR,
      OP_BIT_TO_TRANSFER_FLAG,
      OP_TRANSFER_FLAG_TO_BIT,
      OP_OVERFLOW_FLAG_SET,
      OP_OVERFLOW_FLAG_CLEAR,
      OP_HALF_CARRY_SET,
      OP_HALF_CARRY_CLEAR,
      OP_SIGN_FLAG_SET,
      OP_SIGN_FLAG_CLEAR,
      OP_SLEEP,
      OP_WATCHDOG_RESTART,
      OP_INDIRECT_LOAD,
      OP_INDIRECT_STORE,
      OP_PROGRAM_MEMORY_LOAD,
      OP_NIBBLE_SWAP
   } bsfx_op_t;

   typedef enum logic [1:0] {
      DEST_NONE,
      DEST_REG,
      DEST_IO,
      DEST_MEM
   } bsfx_dest_t;

   typedef enum logic {
      STATE_IDLE,
      STATE_BUSY
   } bsfx_state_t;

   typedef struct packed {
      bsfx_op_t   op;
      logic [7:0] opnd;
      logic [2:0] bitsel;
   } bsfx_req_t;

   typedef struct packed {
      bsfx_dest_t dest;
      logic [7:0] data;
   } bsfx_res_t;

   typedef struct packed {
      logic i;
      logic t;
      logic h;
      logic s;
      logic v;
      logic n;
      logic z;
      logic c;
   } bsfx_flags_t;

endpackage

// File: verification/bsfx_exec_test.sv
// self-checking testbench for the bit, shift and flag execution unit
`timescale 1ns/1ps

module bsfx_exec_test;
   import bsfx_pkg::*;

   logic        clock;
   logic        rst;
   logic        req_valid;
   bsfx_req_t   req;
   logic        req_ready;
   logic        res_valid;
   bsfx_res_t   res;
   bsfx_flags_t status_flags;
   logic        mem_rd;
   logic        mem_wr;
   logic        pmem_rd;
   logic [7:0]  mem_wdata;
   logic [7:0]  mem_rdata;
   logic        sleep_enter;
   logic        wdog_restart;
   logic [7:0]  exp_s;
   int          err_count;
   int          samples_checked;

   bsfx_exec i_bsfx_exec (
      .CLOCK        (clock),
      .RST          (rst),
      .REQ_VALID    (req_valid),
      .REQ          (req),
      .REQ_READY    (req_ready),
      .RES_VALID    (res_valid),
      .RES          (res),
      .STATUS_FLAGS (status_flags),
      .MEM_RD       (mem_rd),
      .MEM_WR       (mem_wr),
      .PMEM_RD      (pmem_rd),
      .MEM_WDATA    (mem_wdata),
      .MEM_RDATA    (mem_rdata),
      .SLEEP_ENTER  (sleep_enter),
      .WDOG_RESTART (wdog_restart)
   );

   initial clock = 1'b0;
   always #25 clock = ~clock;

   task automatic report_and_stop;
      $display("mismatches %0d, comparisons %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_cnt(input int got, input int exp);
      samples_checked++;
      if (got != exp) begin
         err_count++;
         $display("wrong value at %0t: cycles got %h expected %h", $time, got, exp);
      end
   endtask

   // called just after an edge; request stays up while refused, so back to back follows naturally
   task automatic exec(input bsfx_op_t op, input logic [7:0] a, input logic [2:0] b, input bsfx_dest_t d,
                       input logic [7:0] x, input int n, input logic [2:0] stb, input logic [1:0] pls);
      int k;
      req_valid = 1'b1;
      req       = '{op, a, b};
      chk_val({7'h00, req_ready}, 8'h01);
      @(posedge clock);
      #2;
      k = 1;
      chk_val({5'h00, mem_rd, mem_wr, pmem_rd}, {5'h00, stb});
      if (stb[1]) chk_val(mem_wdata, a);
      chk_val({7'h00, req_ready}, {7'h00, n == 1});
      while (res_valid !== 1'b1 && k < 8) begin
         @(posedge clock);
         #2;
         k++;
      end
      if (res_valid !== 1'b1) begin
         err_count++;
         report_and_stop;
      end
      chk_cnt(k, n);
      chk_val({6'h00, sleep_enter, wdog_restart}, {6'h00, pls});
      chk_val({6'h00, res.dest}, {6'h00, d});
      if (d != DEST_NONE) chk_val(res.data, x);
      chk_val(status_flags, exp_s);
   endtask

   // reference result in bits 7..0, new carry in bit 8
   function automatic logic [8:0] ref_shift(input bsfx_op_t op, input logic [7:0] a, input logic c);
      case (op)
         OP_SHIFT_LEFT_LOGICAL:  return {a[7], a[6:0], 1'b0};
         OP_SHIFT_RIGHT_LOGICAL: return {a[0], 1'b0, a[7:1]};
         OP_ROTATE_LEFT_CARRY:   return {a[7], a[6:0], c};
         OP_ROTATE_RIGHT_CARRY:  return {a[0], c, a[7:1]};
         default:                return {a[0], a[7], a[7:1]};
      endcase
   endfunction

   bsfx_op_t   sh_ops [5] = '{OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_LEFT_CARRY,
                              OP_ROTATE_RIGHT_CARRY, OP_SHIFT_RIGHT_ARITH};
   logic [7:0] sh_vals [4] = '{8'h80, 8'h01, 8'hc3, 8'h40};
   bsfx_op_t   fl_ops [6] = '{OP_OVERFLOW_FLAG_SET, OP_OVERFLOW_FLAG_CLEAR, OP_HALF_CARRY_SET,
                              OP_HALF_CARRY_CLEAR, OP_SIGN_FLAG_SET, OP_SIGN_FLAG_CLEAR};
   int         fl_pos [6] = '{3, 3, 5, 5, 4, 4};

   initial begin
      logic [8:0] r;
      err_count       = 0;
      samples_checked = 0;
      rst             = 1'b1;
      req_valid       = 1'b0;
      req             = '{OP_NOP, 8'h00, 3'h0};
      mem_rdata       = 8'h00;
      exp_s           = 8'h00;
      repeat (6) @(posedge clock);
      #2;
      rst = 1'b0;
      chk_val({6'h00, res.dest}, 8'h00);
      chk_val(status_flags, 8'h00);
      // each value meets every shift, with the carry left by the one before
      foreach (sh_vals[j]) begin
         foreach (sh_ops[i]) begin
            r        = ref_shift(sh_ops[i], sh_vals[j], exp_s[0]);
            exp_s[0] = r[8];
            exp_s[2] = r[7];
            exp_s[1] = (r[7:0] == 8'h00);
            exp_s[3] = r[7] ^ r[8];
            exp_s[4] = exp_s[2] ^ exp_s[3];
            exec(sh_ops[i], sh_vals[j], 3'h0, DEST_REG, r[7:0], 1, 3'h0, 2'h0);
         end
      end
      foreach (fl_ops[i]) begin
         exp_s[fl_pos[i]] = (i % 2 == 0);
         exec(fl_ops[i], 8'h00, 3'h0, DEST_NONE, 8'h00, 1, 3'h0, 2'h0);
      end
      exp_s[6] = 1'b1;
      exec(OP_BIT_TO_TRANSFER_FLAG, 8'h10, 3'h4, DEST_NONE, 8'h00, 1, 3'h0, 2'h0);
      exec(OP_TRANSFER_FLAG_TO_BIT, 8'h00, 3'h5, DEST_REG, 8'h20, 1, 3'h0, 2'h0);
      exp_s[6] = 1'b0;
      exec(OP_BIT_TO_TRANSFER_FLAG, 8'hf7, 3'h3, DEST_NONE, 8'h00, 1, 3'h0, 2'h0);
      exec(OP_TRANSFER_FLAG_TO_BIT, 8'hff, 3'h0, DEST_REG, 8'hfe, 1, 3'h0, 2'h0);
      exec(OP_IO_BIT_SET, 8'h00, 3'h7, DEST_IO, 8'h80, 2, 3'h0, 2'h0);
      exec(OP_IO_BIT_CLEAR, 8'hff, 3'h0, DEST_IO, 8'hfe, 2, 3'h0, 2'h0);
      mem_rdata = 8'h5a;
      exec(OP_INDIRECT_LOAD, 8'h00, 3'h0, DEST_REG, 8'h5a, 2, 3'h4, 2'h0);
      exec(OP_INDIRECT_STORE, 8'h3c, 3'h0, DEST_MEM, 8'h3c, 2, 3'h2, 2'h0);
      mem_rdata = 8'ha7;
      exec(OP_PROGRAM_MEMORY_LOAD, 8'h00, 3'h0, DEST_REG, 8'ha7, 3, 3'h1, 2'h0);
      exec(OP_SLEEP, 8'h00, 3'h0, DEST_NONE, 8'h00, 3, 3'h0, 2'h2);
      exec(OP_WATCHDOG_RESTART, 8'h00, 3'h0, DEST_NONE, 8'h00, 1, 3'h0, 2'h1);
      exec(OP_NIBBLE_SWAP, 8'h1e, 3'h0, DEST_REG, 8'he1, 1, 3'h0, 2'h0);
      req_valid = 1'b0;
      repeat (2) @(posedge clock);
      report_and_stop;
   end
endmodule
